/* hw/sram_ctl_pkg.sv */
// package: pin timing counts and request and pin-control carriers for the static memory controller
package sram_ctl_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 40;
  // device timing in ns, fastest grade
  localparam int T_WRITE_PULSE_NS = 10;
  localparam int T_ACCESS_NS = 10;
  localparam int T_OUT_OFF_NS = 7;
  localparam int T_RECOVERY_NS = 15;
  localparam int T_DESEL_RET_NS = 0;
  // cycle counts, minimums rounded up, at least one cycle; read count has two more for the synchroniser
  localparam int WR_CYC_RAW = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;
  localparam int RD_CYC_RAW = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC = ((RD_CYC_RAW < 1) ? 1 : RD_CYC_RAW) + 2;
  localparam int TURN_CYC_RAW = (T_OUT_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC = (TURN_CYC_RAW < 1) ? 1 : TURN_CYC_RAW;
  localparam int REC_CYC_RAW = (T_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = (REC_CYC_RAW < 1) ? 1 : REC_CYC_RAW;
  localparam int DESEL_CYC_RAW = (T_DESEL_RET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DESEL_CYC = (DESEL_CYC_RAW < 1) ? 1 : DESEL_CYC_RAW;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic sel_n;
    logic oe_n;
    logic we_n;
  } mem_ctl_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RD_ADDR = 7'h02,
    ST_RD_WAIT = 7'h04,
    ST_WR_SETUP = 7'h08,
    ST_WR_PULSE = 7'h10,
    ST_WR_END = 7'h20,
    ST_RETAIN = 7'h40
  } ctl_state_t;
endpackage

/* hw/sram_pin_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sram_pin_sync
  import sram_ctl_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

/* hw/sram_ctl.sv */
// host-side controller for a 128K x 8 asynchronous static memory
// Operation
// - select and write strobe low writes data-line byte to addressed location.
// - write lasts only while select and strobe both low; either ends it.
// - host times data setup and hold to the edge ending the write.
// - host does not drive data lines while device drives them.
// - host presents valid address no later than select falls for reads.
// - host deselects device before supply drops to retention level.
`timescale 1ns/10ps
module sram_ctl
  import sram_ctl_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [DATA_W-1:0] i_req_wdata,
  input wire logic i_retain_req,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_retain_ok,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic o_mem_sel_n,
  output logic o_mem_oe_n,
  output logic o_mem_we_n,
  input wire logic [DATA_W-1:0] i_mem_dq,
  output logic [DATA_W-1:0] o_mem_dq,
  output logic o_mem_dq_oe_n
);
  ctl_state_t state_reg;
  ctl_state_t state_next;
  mem_req_t req_in;
  mem_ctl_t ctl_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] turn_reg;
  logic [DATA_W-1:0] dq_sync;
  logic retain_sync_reg;
  logic drive_next;
  logic take_req;

  // data pins come from outside the clock domain
  sram_pin_sync #(.WIDTH(DATA_W)) u_dq_sync (
    .i_clk(I_CLK_SYS),
    .i_arst_n(I_ARST_N),
    .i_async(i_mem_dq),
    .o_sync(dq_sync)
  );

  assign req_in = {i_req_write, i_req_addr, i_req_wdata};
  assign take_req = (state_reg == ST_IDLE) && (state_next != ST_IDLE) && (state_next != ST_RETAIN);

  always_comb begin
    state_next = state_reg;
    cnt_next = (cnt_reg == CNT_ZERO) ? CNT_ZERO : cnt_reg - 4'h1;
    unique case (state_reg)
      ST_IDLE: begin
        if (i_retain_req) begin
          state_next = ST_RETAIN;
          cnt_next = CNT_W'(DESEL_CYC);
        end else if (i_req_valid && req_in.write && turn_reg == CNT_ZERO) begin
          state_next = ST_WR_SETUP;
        end else if (i_req_valid && !req_in.write) begin
          state_next = ST_RD_ADDR;
        end
      end
      ST_RD_ADDR: begin
        state_next = ST_RD_WAIT;
        cnt_next = CNT_W'(RD_CYC);
      end
      ST_RD_WAIT: begin
        if (cnt_reg == CNT_ZERO) begin
          state_next = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        state_next = ST_WR_PULSE;
        cnt_next = CNT_W'(WR_CYC - 1);
      end
      ST_WR_PULSE: begin
        if (cnt_reg == CNT_ZERO) begin
          state_next = ST_WR_END;
        end
      end
      ST_WR_END: begin
        state_next = ST_IDLE;
      end
      ST_RETAIN: begin
        if (!i_retain_req) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // pin controls per state; strobe and select only go low inside an access
  always_comb begin
    ctl_next = '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    drive_next = 1'b0;
    unique case (state_next)
      ST_IDLE, ST_RETAIN: begin
        ctl_next = '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      end
      ST_RD_ADDR, ST_RD_WAIT: begin
        ctl_next = '{sel_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
      end
      ST_WR_SETUP: begin
        ctl_next = '{sel_n: 1'b0, oe_n: 1'b1, we_n: 1'b1};
        drive_next = 1'b1;
      end
      ST_WR_PULSE: begin
        ctl_next = '{sel_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
        drive_next = 1'b1;
      end
      ST_WR_END: begin
        // strobe rises first, data held one cycle after the ending edge
        ctl_next = '{sel_n: 1'b0, oe_n: 1'b1, we_n: 1'b1};
        drive_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // request latch; address changes on the same edge that select falls
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_mem_addr <= '0;
    end else if (take_req) begin
      o_mem_addr <= req_in.addr;
    end
  end

  // write byte launched with the address, so it is long settled when the strobe rises
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_mem_dq <= '0;
    end else if (take_req) begin
      o_mem_dq <= req_in.wdata;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_mem_sel_n <= 1'b1;
    end else begin
      o_mem_sel_n <= ctl_next.sel_n;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_mem_oe_n <= 1'b1;
    end else begin
      o_mem_oe_n <= ctl_next.oe_n;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_mem_we_n <= 1'b1;
    end else begin
      o_mem_we_n <= ctl_next.we_n;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_mem_dq_oe_n <= 1'b1;
    end else begin
      o_mem_dq_oe_n <= !drive_next;
    end
  end

  // bus turnaround guard after a read so the device has released the lines
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      turn_reg <= CNT_ZERO;
    end else if (state_reg == ST_RD_WAIT) begin
      turn_reg <= CNT_W'(TURN_CYC);
    end else if (turn_reg != CNT_ZERO) begin
      turn_reg <= turn_reg - 4'h1;
    end
  end

  // read data taken after synchroniser latency; never-written bytes return whatever the array holds
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
    end else begin
      o_rd_valid <= (state_reg == ST_RD_WAIT) && (cnt_reg == CNT_ZERO);
      if (state_reg == ST_RD_WAIT && cnt_reg == CNT_ZERO) begin
        o_rd_data <= dq_sync;
      end
    end
  end

  // retention wins over a waiting request, so ready drops as soon as it is asked for
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_req_ready <= 1'b0;
    end else begin
      o_req_ready <= (state_next == ST_IDLE) && !i_retain_req;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      o_retain_ok <= 1'b0;
      retain_sync_reg <= 1'b0;
    end else begin
      retain_sync_reg <= (state_reg == ST_RETAIN) && (cnt_reg == CNT_ZERO);
      o_retain_ok <= retain_sync_reg && (state_reg == ST_RETAIN);
    end
  end
endmodule

/* dv/sram_ctl_props.sv */
// checker: pin-level properties of the memory controller
`timescale 1ns/10ps
module sram_ctl_props import sram_ctl_pkg::*; (
  input wire logic I_CLK_SYS, I_ARST_N, i_req_valid, i_req_write, i_retain_req, o_req_ready, o_rd_valid,
  input wire logic o_retain_ok, o_mem_sel_n, o_mem_oe_n, o_mem_we_n, o_mem_dq_oe_n,
  input wire logic [DATA_W-1:0] o_mem_dq
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_ARST_N);
  AST_WE_SEL: assert property (!o_mem_we_n |-> !o_mem_sel_n && !o_mem_dq_oe_n) else $error("strobe");
  AST_WE_PULSE: assert property ($fell(o_mem_we_n) |=> $rose(o_mem_we_n)) else $error("pulse");
  AST_WR_END: assert property ($rose(o_mem_we_n) |-> !o_mem_sel_n && $stable(o_mem_dq)) else $error("end");
  AST_NO_FIGHT: assert property (!o_mem_oe_n |-> o_mem_dq_oe_n && o_mem_we_n) else $error("fight");
  AST_RETAIN: assert property (o_retain_ok |-> o_mem_sel_n) else $error("retain");
  AST_RD_LAT: assert property (i_req_valid && o_req_ready && !i_req_write && !i_retain_req |-> ##6 o_rd_valid)
    else $error("latency");
  AST_RD_PINS: assert property (o_rd_valid |-> o_mem_oe_n && !$past(o_mem_oe_n)) else $error("pins");
  AST_RD_ONE: assert property (o_rd_valid |=> !o_rd_valid) else $error("valid");
  cover property (o_rd_valid);
  cover property ($rose(o_mem_we_n));
  cover property (o_retain_ok);
endmodule
bind sram_ctl sram_ctl_props i_props (.I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .i_req_valid(i_req_valid),
  .i_req_write(i_req_write), .i_retain_req(i_retain_req), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
  .o_retain_ok(o_retain_ok), .o_mem_sel_n(o_mem_sel_n), .o_mem_oe_n(o_mem_oe_n), .o_mem_we_n(o_mem_we_n),
  .o_mem_dq_oe_n(o_mem_dq_oe_n), .o_mem_dq(o_mem_dq));

/* dv/sram_dev_model.sv */
// behavioural static memory with data wire resolution
`timescale 1ns/10ps
module sram_dev_model import sram_ctl_pkg::*; #(parameter int DLY = 30) (
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_sel_n, i_oe_n, i_we_n, i_dq_oe_n,
  input wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0] o_dq
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last = 8'h00;
  wire standby = i_sel_n;
  wire drv = !standby && !i_oe_n && i_we_n;
  always @* if (!i_sel_n && !i_we_n) mem[i_addr] = i_dq;
  always @(o_dq) if (drv || !i_dq_oe_n) last = o_dq;
  // a released wire shows the inverse, so a stale byte never reads as good
  assign #(DLY) o_dq = drv ? (i_dq_oe_n ? mem[i_addr] : 'x) : (!i_dq_oe_n ? i_dq : ~last);
endmodule

/* dv/tb.sv */
// self-checking bench: corner and random transfers, retention handshake
`timescale 1ns/10ps
module tb;
  import sram_ctl_pkg::*;
  logic I_CLK_SYS = 0, I_ARST_N = 0, vld = 0, wr = 0, ret = 0, rdy, rv, rok, sel_n, oe_n, we_n, dq_oe_n;
  logic [ADDR_W-1:0] adr = '0, ma;
  logic [DATA_W-1:0] wd = '0, rd, mq, dq;
  logic [DATA_W-1:0] shadow [int];
  logic [31:0] seed = 32'hD8021D2F;
  int err_count = 0, num_checks = 0;
  sram_ctl i_sram_ctl (.I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .i_req_valid(vld), .i_req_write(wr),
    .i_req_addr(adr), .i_req_wdata(wd), .i_retain_req(ret), .o_req_ready(rdy), .o_rd_valid(rv),
    .o_rd_data(rd), .o_retain_ok(rok), .o_mem_addr(ma), .o_mem_sel_n(sel_n), .o_mem_oe_n(oe_n),
    .o_mem_we_n(we_n), .i_mem_dq(dq), .o_mem_dq(mq), .o_mem_dq_oe_n(dq_oe_n));
  sram_dev_model i_sram_dev_model (.i_addr(ma), .i_sel_n(sel_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_dq_oe_n(dq_oe_n), .i_dq(mq), .o_dq(dq));
  initial forever #20 I_CLK_SYS = ~I_CLK_SYS;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [DATA_W-1:0] exp_rd(logic [ADDR_W-1:0] a);
    return shadow.exists(a) ? shadow[a] : 'x;
  endfunction
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic xfer(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    int n;
    @(negedge I_CLK_SYS);
    while (!rdy) @(negedge I_CLK_SYS);
    {vld, wr, adr, wd} = {1'b1, w, a, d};
    // a write may be held back by the turnaround guard, so wait for ready to drop
    do @(posedge I_CLK_SYS); while (rdy);
    n = 0;
    @(negedge I_CLK_SYS);
    vld = 0;
    if (w) shadow[a] = d;
    else begin
      while (!rv && n < 20) begin
        @(posedge I_CLK_SYS);
        #1;
        n++;
      end
      // counting starts one edge after the take edge; valid lands RD_CYC + 2 edges after it
      chk("read latency", n, RD_CYC + 1);
      chk("read data", rd, exp_rd(a));
    end
  endtask
  initial begin
    repeat (8) @(posedge I_CLK_SYS);
    chk("reset pins", {sel_n, oe_n, we_n, dq_oe_n, rdy}, 5'h1E);
    @(negedge I_CLK_SYS);
    I_ARST_N = 1;
    xfer(1, 17'h1FFFF, 8'hA5);
    xfer(1, 17'h00000, 8'h5A);
    xfer(0, 17'h1FFFF, 8'h00);
    xfer(0, 17'h00000, 8'h00);
    xfer(0, 17'h00123, 8'h00);
    $display("test corners done");
    repeat (60) xfer(1'(xs()), ADDR_W'(xs() & 32'hF), DATA_W'(xs()));
    $display("test random done");
    @(negedge I_CLK_SYS);
    // the last random write may still be finishing; retention is only taken when idle
    while (!rdy) @(negedge I_CLK_SYS);
    {ret, vld, wr, adr} = {1'b1, 1'b1, 1'b0, 17'h1FFFF};
    repeat (4) @(posedge I_CLK_SYS);
    #1;
    chk("retain", {rok, sel_n, rdy, rv}, 4'hC);
    @(negedge I_CLK_SYS);
    {ret, vld} = 2'b00;
    xfer(0, 17'h1FFFF, 8'h00);
    $display("test retain done");
    end_sim();
  end
  // about 70 transfers of at most ten cycles each; far more than that means a hang
  initial begin
    #(4000 * CLK_PERIOD_NS);
    err_count++;
    end_sim();
  end
endmodule
